//--- logic/dfel_cfg.svh
// Offsets, field positions, reset values and timing figures of the fault latch block
`ifndef DFEL_CFG_SVH
`define DFEL_CFG_SVH

// ----------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------
`define DFEL_ADDR_W       8
`define DFEL_REG_STATUS   8'h00
`define DFEL_REG_IRQ_STAT 8'h04
`define DFEL_REG_IRQ_MASK 8'h08
`define DFEL_REG_CTRL     8'h0C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DFEL_ST_FAULT     0
`define DFEL_ST_NST       1
`define DFEL_ST_SEEK_ERR  2
`define DFEL_ST_LOCK      3
`define DFEL_ST_READY     4
`define DFEL_ST_ERR_LSB   8
`define DFEL_CTRL_MAINT   0
`define DFEL_IRQ_W        4
`define DFEL_IRQ_FAULT    0
`define DFEL_IRQ_NST      1
`define DFEL_IRQ_SEEK     2
`define DFEL_IRQ_LOCK     3
`define DFEL_IRQ_MASK_RST 4'h0

// ----------------------------------------------------------------
// Device figures and timing
// ----------------------------------------------------------------
`define DFEL_HEADS        5
`define DFEL_CYL_W        10
`define DFEL_MAX_CYL      10'h336
`define DFEL_CLK_KHZ      20000
`define DFEL_NST_MS       350
`define DFEL_SEEK_MS      500
`define DFEL_WGAP_CYC     16
`define DFEL_TMR_W        24

`endif

//--- logic/dfel_pkg.sv
// Types shared by the fault latch block, its assertions and its bench
package dfel_pkg;

  // Write channel health sense lines
  typedef struct packed {
    logic wdrv_out_low;
    logic wdrv_cur_low;
    logic v22_low;
    logic wdata_edge;
  } dfel_wr_sense_t;

  // Supply comparators, high means below operating level
  typedef struct packed {
    logic v42_low;
    logic v5_low;
    logic v20_low;
  } dfel_supply_t;

  // Release requests from panel, fault card and controller
  typedef struct packed {
    logic panel_sw;
    logic maint_sw;
    logic ctl_release;
    logic ctl_master;
  } dfel_clear_t;

  // Per-error latches
  typedef struct packed {
    logic volt;
    logic offcyl;
    logic rw;
    logic head;
    logic wr;
  } dfel_err_t;

  // Whole state of the top module
  typedef struct packed {
    logic        fault;
    dfel_err_t   err;
    logic        nst;
    logic        seek_err;
    logic        lock;
    logic        load_busy;
    logic        seek_busy;
    logic        rtz_pulse;
    logic        maint_req;
    logic [3:0]  irq_stat;
    logic [3:0]  irq_mask;
    logic [31:0] rdata;
  } dfel_state_t;

endpackage

//--- logic/dfel_timer.sv
// Timeout counter whose flag rises one count before its limit and holds there while running
`timescale 1ns/1ns
`include "dfel_cfg.svh"

module dfel_timer #(
  parameter int              W     = `DFEL_TMR_W,
  parameter logic [W-1:0]    LIMIT = '1
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic clear,
  input  wire logic run,
  output logic      expired
);

  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;
  logic         hit;

  // Count stops at the limit instead of wrapping
  assign hit = (count_r == LIMIT - W'(1));

  always_comb begin
    count_nxt = count_r;
    if (clear) begin
      count_nxt = '0;
    end else if (run && !hit && count_r != LIMIT) begin
      count_nxt = count_r + W'(1);
    end else if (run && hit) begin
      count_nxt = LIMIT;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  // High from one count before the limit on while still running, so a stall stays visible
  assign expired = run && !clear && (hit || count_r == LIMIT);

endmodule

//--- logic/dfel_top.sv
// Fault, per-error, no-servo-tracks and seek error latches of the drive
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/1ns
`include "dfel_cfg.svh"

// Operation
// - Fault latch: fault line, lamp, not ready, inhibit
// - Fault releases by any clear, causes gone
// - Per-error latches cleared only by strong clears
// - Write fault from driver, supply, transitions
// - More than one head enabled is fault
// - Read and write windows together fault
// - Read or write while unsettled faults
// - Low 42, 5 or 20 volt rail faults
// - Low speed/voltage: lockout, retract, lockout unlatched
// - No dibits in 350 ms: latch, unload
// - No-servo latch blocks loads, fault-style release
// - Seek error: timeout, travel limit, bad cylinder
// - Seek error line, seeks refused, zero seek clears
module dfel_top
  import dfel_pkg::*;
#(
  parameter int unsigned NST_CYC  = `DFEL_NST_MS * `DFEL_CLK_KHZ,
  parameter int unsigned SEEK_CYC = `DFEL_SEEK_MS * `DFEL_CLK_KHZ,
  parameter int unsigned WGAP_CYC = `DFEL_WGAP_CYC,
  parameter int          HEADS    = `DFEL_HEADS,
  parameter int          CYL_W    = `DFEL_CYL_W
) (
  input  wire logic                     clk,
  input  wire logic                     reset,
  // Register port
  input  wire logic [`DFEL_ADDR_W-1:0]  addr,
  input  wire logic [31:0]              wdata,
  input  wire logic                     wr_stb,
  input  wire logic                     rd_stb,
  output logic      [31:0]              rdata,
  output logic                          irq,
  // Release sources
  input  wire dfel_pkg::dfel_clear_t    clr,
  // Sense lines
  input  wire dfel_pkg::dfel_wr_sense_t wr_sense,
  input  wire dfel_pkg::dfel_supply_t   supply,
  input  wire logic                     speed_low,
  input  wire logic [HEADS-1:0]         head_en,
  input  wire logic                     read_gate,
  input  wire logic                     write_gate,
  input  wire logic                     track_unsettled,
  // Load and seek sequencing
  input  wire logic                     load_start,
  input  wire logic                     dibit_seen,
  input  wire logic                     seek_start,
  input  wire logic [CYL_W-1:0]         seek_cyl,
  input  wire logic                     travel_limit,
  input  wire logic                     zero_seek_cmd,
  // Outputs toward controller, panel and servo
  output logic                          fault_line,
  output logic                          fault_lamp,
  output logic                          unit_ready,
  output logic                          write_inhibit,
  output logic                          load_inhibit,
  output logic                          write_lockout,
  output logic                          emergency_retract,
  output logic                          return_to_zero_seek,
  output logic                          seek_error,
  output logic                          seek_inhibit,
  output logic                          load_busy,
  output logic                          seek_busy
);

  import dfel_pkg::*;

  // ----------------------------------------------------------------
  // State and timers
  // ----------------------------------------------------------------
  dfel_state_t s_r;
  dfel_state_t s_nxt;

  dfel_err_t   err_now;
  logic        cause_now;
  logic        rel_any;
  logic        rel_strong;
  logic        lock_now;
  logic        load_go;
  logic        seek_go;
  logic        bad_cyl;
  logic        nst_exp;
  logic        seek_exp;
  logic        wgap_exp;
  logic        fault_set;
  logic        nst_set;
  logic        seek_set;
  logic [3:0]  ev;
  logic [31:0] status_word;

  // Dibit search window after a load starts
  dfel_timer #(
    .W     (`DFEL_TMR_W),
    .LIMIT (`DFEL_TMR_W'(NST_CYC))
  ) u_nst_tmr (
    .clk     (clk),
    .reset   (reset),
    .clear   (load_go),
    .run     (s_r.load_busy),
    .expired (nst_exp)
  );

  // Settle window after a seek starts
  dfel_timer #(
    .W     (`DFEL_TMR_W),
    .LIMIT (`DFEL_TMR_W'(SEEK_CYC))
  ) u_seek_tmr (
    .clk     (clk),
    .reset   (reset),
    .clear   (seek_go),
    .run     (s_r.seek_busy),
    .expired (seek_exp)
  );

  // Gap without write data transitions inside the write window
  dfel_timer #(
    .W     (`DFEL_TMR_W),
    .LIMIT (`DFEL_TMR_W'(WGAP_CYC))
  ) u_wgap_tmr (
    .clk     (clk),
    .reset   (reset),
    .clear   (wr_sense.wdata_edge || !write_gate),
    .run     (write_gate),
    .expired (wgap_exp)
  );

  // ----------------------------------------------------------------
  // Fault causes
  // ----------------------------------------------------------------
  // Write channel faults
  assign err_now.wr = wr_sense.wdrv_out_low || wr_sense.wdrv_cur_low
                      || wr_sense.v22_low || wgap_exp;
  // Any two heads enabled at once
  assign err_now.head   = |(head_en & (head_en - HEADS'(1)));
  assign err_now.rw     = read_gate && write_gate;
  assign err_now.offcyl = (read_gate || write_gate) && track_unsettled;
  assign err_now.volt   = supply.v42_low || supply.v5_low || supply.v20_low;

  // Every cause, the write data gap included, is a level that blocks release
  assign cause_now = |err_now;

  // Release groups; the strong group also clears per-error history
  assign rel_any    = clr.panel_sw || clr.maint_sw || clr.ctl_release
                      || clr.ctl_master || s_r.maint_req;
  assign rel_strong = clr.maint_sw || clr.ctl_master || s_r.maint_req;

  // Speed or supply trouble locks out writing and retracts; only supply trouble faults
  assign lock_now = speed_low || err_now.volt;

  // ----------------------------------------------------------------
  // Load and seek acceptance
  // ----------------------------------------------------------------
  // Loads refused while the no-servo latch or the fault latch stands
  assign load_go = load_start && !s_r.nst && !s_r.fault;
  // Seeks refused while the seek error latch stands
  assign seek_go = seek_start && !s_r.seek_err;
  assign bad_cyl = seek_go && (seek_cyl > CYL_W'(`DFEL_MAX_CYL));

  assign fault_set = cause_now;
  assign nst_set   = nst_exp && !dibit_seen;
  assign seek_set  = (seek_exp && track_unsettled) || travel_limit
                     || bad_cyl;

  // ----------------------------------------------------------------
  // Status word seen by software
  // ----------------------------------------------------------------
  always_comb begin
    status_word = '0;
    status_word[`DFEL_ST_FAULT]    = s_r.fault;
    status_word[`DFEL_ST_NST]      = s_r.nst;
    status_word[`DFEL_ST_SEEK_ERR] = s_r.seek_err;
    status_word[`DFEL_ST_LOCK]     = s_r.lock;
    status_word[`DFEL_ST_READY]    = unit_ready;
    status_word[`DFEL_ST_ERR_LSB +: 5] = s_r.err;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;

    // Shared fault latch: release needs all causes gone, set wins
    if (rel_any && !cause_now) begin
      s_nxt.fault = 1'b0;
    end
    if (fault_set) begin
      s_nxt.fault = 1'b1;
    end

    // Per-error history survives the ordinary releases
    if (rel_strong) begin
      s_nxt.err = '0;
    end
    s_nxt.err = s_nxt.err | err_now;

    // Load window: ends on first dibit or on timeout
    if (load_go) begin
      s_nxt.load_busy = 1'b1;
    end else if (dibit_seen || nst_exp) begin
      s_nxt.load_busy = 1'b0;
    end

    // No-servo-tracks latch, same release as the fault latch
    if (rel_any) begin
      s_nxt.nst = 1'b0;
    end
    if (nst_set) begin
      s_nxt.nst = 1'b1;
    end
    // Unload request to the zero seek logic, one cycle
    s_nxt.rtz_pulse = nst_set;

    // Seek window: ends when settled, on timeout or on error
    if (seek_go && !bad_cyl) begin
      s_nxt.seek_busy = 1'b1;
    end else if (!track_unsettled || seek_exp || seek_set) begin
      s_nxt.seek_busy = 1'b0;
    end

    // Seek error latch, only a zero seek releases it
    if (zero_seek_cmd) begin
      s_nxt.seek_err = 1'b0;
    end
    if (seek_set) begin
      s_nxt.seek_err = 1'b1;
    end

    // Write lockout follows its causes, never latched
    s_nxt.lock = lock_now;

    // Register writes
    s_nxt.maint_req = 1'b0;
    if (wr_stb) begin
      unique case (addr)
        `DFEL_REG_IRQ_STAT: s_nxt.irq_stat = s_r.irq_stat & ~wdata[3:0];
        `DFEL_REG_IRQ_MASK: s_nxt.irq_mask = wdata[3:0];
        `DFEL_REG_CTRL:     s_nxt.maint_req = wdata[`DFEL_CTRL_MAINT];
        default: ;
      endcase
    end

    // Events on rising latch edges; a set beats a same-cycle clear
    ev = '0;
    ev[`DFEL_IRQ_FAULT] = s_nxt.fault && !s_r.fault;
    ev[`DFEL_IRQ_NST]   = s_nxt.nst && !s_r.nst;
    ev[`DFEL_IRQ_SEEK]  = s_nxt.seek_err && !s_r.seek_err;
    ev[`DFEL_IRQ_LOCK]  = lock_now && !s_r.lock;
    s_nxt.irq_stat = s_nxt.irq_stat | ev;

    // Read data valid in the cycle after the strobe only
    s_nxt.rdata = '0;
    if (rd_stb) begin
      unique case (addr)
        `DFEL_REG_STATUS:   s_nxt.rdata = status_word;
        `DFEL_REG_IRQ_STAT: s_nxt.rdata = {28'h0000000, s_r.irq_stat};
        `DFEL_REG_IRQ_MASK: s_nxt.rdata = {28'h0000000, s_r.irq_mask};
        default:            s_nxt.rdata = '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Power-down clears every latch; reset is the power-up release
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_r <= '{fault: 1'b0, err: '0, nst: 1'b0, seek_err: 1'b0,
               lock: 1'b0, load_busy: 1'b0, seek_busy: 1'b0,
               rtz_pulse: 1'b0, maint_req: 1'b0, irq_stat: '0,
               irq_mask: `DFEL_IRQ_MASK_RST, rdata: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Fault latch drives line, lamp, ready and the write and load inhibits
  assign fault_line          = s_r.fault;
  assign fault_lamp          = s_r.fault || s_r.nst;
  assign unit_ready          = !s_r.fault;
  assign write_inhibit       = s_r.fault || s_r.lock;
  assign load_inhibit        = s_r.fault || s_r.nst;
  assign write_lockout       = s_r.lock;
  assign emergency_retract   = s_r.lock;
  assign return_to_zero_seek = s_r.rtz_pulse;
  assign seek_error          = s_r.seek_err;
  assign seek_inhibit        = s_r.seek_err;
  assign load_busy           = s_r.load_busy;
  assign seek_busy           = s_r.seek_busy;
  assign rdata               = s_r.rdata;
  // Level interrupt while any unmasked event bit stands
  assign irq                 = |(s_r.irq_stat & s_r.irq_mask);

endmodule

//--- verification/dfel_sva.sv
// Port-level assertions for the fault latch block
`timescale 1ns/1ns
module dfel_sva
  import dfel_pkg::*;
#(
  parameter int CYL_W = 10
) (
  input wire logic                  clk,
  input wire logic                  reset,
  input wire dfel_pkg::dfel_clear_t clr,
  input wire dfel_pkg::dfel_supply_t supply,
  input wire logic                  speed_low,
  input wire logic                  read_gate,
  input wire logic                  write_gate,
  input wire logic                  track_unsettled,
  input wire logic                  load_start,
  input wire logic                  seek_start,
  input wire logic [CYL_W-1:0]      seek_cyl,
  input wire logic                  zero_seek_cmd,
  input wire logic                  fault_line,
  input wire logic                  fault_lamp,
  input wire logic                  unit_ready,
  input wire logic                  write_inhibit,
  input wire logic                  load_inhibit,
  input wire logic                  write_lockout,
  input wire logic                  emergency_retract,
  input wire logic                  return_to_zero_seek,
  input wire logic                  seek_error,
  input wire logic                  seek_inhibit,
  input wire logic                  load_busy
);
  // ----------------------------------------
  // One clock, one power-down reset
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  // Out-of-range target with seeks still allowed
  sequence bad_seek;
    seek_start && !seek_inhibit && seek_cyl > 10'h336;
  endsequence
  // Unload request lasts a single cycle
  sequence rtz_once;
    fault_lamp && load_inhibit ##1 !return_to_zero_seek;
  endsequence

  fault_outs_a: assert property (
    fault_line |-> fault_lamp && !unit_ready && write_inhibit && load_inhibit)
    else $error("fault line without lamp, not-ready or inhibits");
  fault_hold_a: assert property (
    fault_line && clr == '0 |=> fault_line)
    else $error("fault latch dropped without a release");
  gate_both_a: assert property (
    read_gate && write_gate |=> fault_line && !unit_ready)
    else $error("read and write windows together did not fault");
  gate_unsettled_a: assert property (
    (read_gate || write_gate) && track_unsettled |=> fault_line)
    else $error("window while off cylinder did not fault");
  supply_fault_a: assert property (
    supply != '0 |=> fault_line && write_lockout)
    else $error("low rail without fault and lockout");
  lockout_on_a: assert property (
    speed_low [*2] |-> write_lockout && emergency_retract && write_inhibit)
    else $error("low speed without lockout and retract");
  lockout_off_a: assert property (
    $fell(speed_low) && supply == '0 |=> !write_lockout)
    else $error("lockout held after speed recovered");
  unload_pulse_a: assert property (
    return_to_zero_seek |-> rtz_once)
    else $error("unload pulse without lamp or longer than a cycle");
  load_refuse_a: assert property (
    load_start && load_inhibit && !load_busy |=> !load_busy)
    else $error("head load started while inhibited");
  seek_range_a: assert property (
    bad_seek |=> seek_error && seek_inhibit)
    else $error("cylinder above range did not set seek error");
  seek_hold_a: assert property (
    seek_error && !zero_seek_cmd |=> seek_error)
    else $error("seek error dropped without a zero seek");
endmodule

bind dfel_top dfel_sva #(.CYL_W(CYL_W)) u_sva (
  .clk, .reset, .clr, .supply, .speed_low, .read_gate, .write_gate,
  .track_unsettled, .load_start, .seek_start, .seek_cyl, .zero_seek_cmd,
  .fault_line, .fault_lamp, .unit_ready, .write_inhibit, .load_inhibit,
  .write_lockout, .emergency_retract, .return_to_zero_seek, .seek_error,
  .seek_inhibit, .load_busy
);

//--- verification/dfel_ctl_model.sv
// Controller stand-in: data windows, write data edges and zero seeks
`timescale 1ns/1ns
module dfel_ctl_model (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic rd_win,
  input  wire logic wr_win,
  input  wire logic mute,
  input  wire logic slow,
  input  wire logic seek_error,
  output logic      read_gate,
  output logic      write_gate,
  output logic      wdata_edge,
  output logic      zero_seek_cmd
);
  logic [3:0] wait_r;

  // Windows follow requests; mute starves the write data on purpose
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      {read_gate, write_gate, wdata_edge, zero_seek_cmd} <= '0;
      wait_r <= '0;
    end else begin
      read_gate <= rd_win;
      write_gate <= wr_win;
      wdata_edge <= wr_win && !mute && !wdata_edge;
      // Only a zero seek clears the latch; slow answer retries on wrap
      zero_seek_cmd <= seek_error && wait_r == (slow ? 4'h8 : 4'h0);
      wait_r <= seek_error ? wait_r + 4'h1 : 4'h0;
    end
  end
endmodule

//--- verification/dfel_tb.sv
// Self-checking bench for the fault latch block
`timescale 1ns/1ns
module testbench;
  import dfel_pkg::*;
  logic         clk, reset, wr_stb, rd_stb, irq, speed_low, track_unsettled;
  logic         rd_win, wr_win, mute, slow, read_gate, write_gate, wdata_edge;
  logic         zero_seek_cmd, fault_line, fault_lamp, unit_ready, dibit_seen;
  logic         write_inhibit, load_inhibit, write_lockout, emergency_retract;
  logic         return_to_zero_seek, seek_error, seek_inhibit, load_busy, seek_busy;
  logic [2:0]   go, wsense;
  logic [4:0]   head_en, err_acc;
  logic [7:0]   addr;
  logic [9:0]   seek_cyl;
  logic [31:0]  wdata, rdata;
  dfel_clear_t  clr;
  dfel_supply_t supply;
  int           n_errors, n_tests, i, k, c, w;

  // Short timeouts keep the run brief
  dfel_top #(.NST_CYC(20), .SEEK_CYC(30), .WGAP_CYC(4)) DUT (
    .clk, .reset, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .irq, .clr,
    .wr_sense({wsense, wdata_edge}), .supply, .speed_low, .head_en, .read_gate,
    .write_gate, .track_unsettled, .load_start(go[0]), .dibit_seen,
    .seek_start(go[1]), .seek_cyl, .travel_limit(go[2]), .zero_seek_cmd,
    .fault_line, .fault_lamp, .unit_ready, .write_inhibit, .load_inhibit,
    .write_lockout, .emergency_retract, .return_to_zero_seek, .seek_error,
    .seek_inhibit, .load_busy, .seek_busy
  );
  dfel_ctl_model CTL (
    .clk, .reset, .rd_win, .wr_win, .mute, .slow, .seek_error, .read_gate,
    .write_gate, .wdata_edge, .zero_seek_cmd
  );

  // ----------------------------------------
  // Clock, checks and bus helpers
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic conclude();
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic cmpw(logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmpb(logic got, logic exp);
    cmpw({31'h0, got}, {31'h0, exp});
  endtask

  // A bounded wait that ran out ends the run
  task automatic need(logic got);
    cmpb(got, 1'b1);
    if (got !== 1'b1) conclude();
  endtask

  // Which per-error latch a cause index lands in
  function automatic logic [4:0] errbit(int n);
    return 5'h1 << (n == 5 ? 0 : n);
  endfunction

  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    @(negedge clk);
    cmpw(rdata, e);
  endtask

  task automatic rel(int j);
    @(posedge clk);
    clr <= dfel_clear_t'(4'h1 << j);
    @(posedge clk);
    clr <= '0;
  endtask

  task automatic pulse(int j);
    @(posedge clk);
    go <= 3'h1 << j;
    @(posedge clk);
    go <= '0;
  endtask

  // Drop every fault and lockout cause together
  task automatic idle();
    @(posedge clk);
    {wsense, head_en, supply, rd_win, wr_win, mute, track_unsettled} <= '0;
    speed_low <= 1'b0;
  endtask

  // Hang guard, about 40000 cycles
  initial begin
    #2000000;
    n_errors++;
    conclude();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {wr_stb, rd_stb, speed_low, track_unsettled, dibit_seen, rd_win, wr_win} = '0;
    {mute, slow, go, wsense, head_en, addr, seek_cyl, wdata, clr, supply} = '0;
    {n_errors, n_tests, err_acc} = '0;
    reset = 1'b1;
    w = $urandom(37949);
    cyc(8);
    reset <= 1'b0;
    rd(8'h00, 32'h10);
    rd(8'h08, 32'h0);
    rd(8'h20, 32'h0);
    // Every cause, a refused release while it lasts, then a random release
    for (i = 0; i < 12; i++) begin
      k = i % 6;
      c = $urandom_range(0, 3);
      @(posedge clk);
      case (k)
        0: wsense <= 3'h1 << $urandom_range(0, 2);
        1: head_en <= 5'h3 << $urandom_range(0, 3);
        2: {rd_win, wr_win} <= 2'h3;
        3: {rd_win, track_unsettled} <= 2'h3;
        4: supply <= 3'h1 << $urandom_range(0, 2);
        default: {wr_win, mute} <= 2'h3;
      endcase
      cyc(8);
      rel(c);
      @(negedge clk);
      cmpb(fault_line, 1'b1);
      cmpb(unit_ready, 1'b0);
      cmpb(fault_lamp & write_inhibit & load_inhibit, 1'b1);
      cmpb(write_lockout, k == 4);
      idle();
      cyc(2);
      @(negedge clk);
      cmpb(fault_line, 1'b1);
      rel(c);
      @(negedge clk);
      cmpb(fault_line, 1'b0);
      err_acc = (c % 2 == 0) ? 5'h0 : (err_acc | errbit(k));
      rd(8'h00, {19'h0, err_acc, 8'h10});
    end
    // Interrupt raised, masked, cleared
    wr(8'h04, 32'hF);
    wr(8'h08, 32'h1);
    @(posedge clk);
    head_en <= 5'h5;
    cyc(3);
    @(negedge clk);
    cmpb(irq, 1'b1);
    wr(8'h08, 32'h0);
    @(negedge clk);
    cmpb(irq, 1'b0);
    idle();
    rel(0);
    wr(8'h04, 32'h1);
    rd(8'h04, 32'h0);
    // Low spindle speed locks writes without latching a fault
    @(posedge clk);
    speed_low <= 1'b1;
    cyc(2);
    @(negedge clk);
    cmpb(write_lockout & emergency_retract & write_inhibit, 1'b1);
    cmpb(fault_line, 1'b0);
    idle();
    cyc(1);
    @(negedge clk);
    cmpb(write_lockout, 1'b0);
    rd(8'h04, 32'h8);
    wr(8'h04, 32'hF);
    // Load with no dibits times out, unloads, refuses the next load
    pulse(0);
    for (w = 0; w < 40 && return_to_zero_seek !== 1'b1; w++) @(negedge clk);
    need(return_to_zero_seek);
    cmpb(fault_lamp, 1'b1);
    rd(8'h00, 32'h12);
    pulse(0);
    cyc(1);
    @(negedge clk);
    cmpb(load_busy, 1'b0);
    rel($urandom_range(0, 3));
    @(negedge clk);
    cmpb(fault_lamp | load_inhibit, 1'b0);
    pulse(0);
    cyc(4);
    dibit_seen <= 1'b1;
    cyc(30);
    @(negedge clk);
    cmpb(fault_lamp | load_busy, 1'b0);
    // Seek past the last cylinder, refused seek, slow zero seek answer
    @(posedge clk);
    slow <= 1'b1;
    seek_cyl <= 10'h337;
    pulse(1);
    @(negedge clk);
    cmpb(seek_error & seek_inhibit, 1'b1);
    @(posedge clk);
    seek_cyl <= 10'h10;
    pulse(1);
    @(negedge clk);
    cmpb(seek_busy, 1'b0);
    for (w = 0; w < 20 && seek_error !== 1'b0; w++) @(negedge clk);
    need(!seek_error);
    @(posedge clk);
    slow <= 1'b0;
    seek_cyl <= 10'h336;
    pulse(1);
    cyc(3);
    @(negedge clk);
    cmpb(seek_error, 1'b0);
    // Never settling, then a travel limit
    @(posedge clk);
    track_unsettled <= 1'b1;
    seek_cyl <= 10'($urandom_range(0, 822));
    pulse(1);
    @(negedge clk);
    cmpb(seek_busy, 1'b1);
    for (w = 0; w < 50 && seek_error !== 1'b1; w++) @(negedge clk);
    need(seek_error);
    idle();
    cyc(6);
    pulse(2);
    @(negedge clk);
    cmpb(seek_error, 1'b1);
    for (w = 0; w < 10 && seek_error !== 1'b0; w++) @(negedge clk);
    need(!seek_error);
    wr(8'h0C, 32'h1);
    rd(8'h00, 32'h10);
    conclude();
  end
endmodule
